// ==== bench/tb_top.sv ====
/*
 self-checking bench for wdtu_core: register access over axi4-lite, protected writes, safety levels.
 assumes the rtl/ files are compiled first; the tick divider is shortened so time-outs fit the run.
*/
`timescale 1ns/10ps
`include "wdtu_params.svh"
module tb_top
    import wdtu_pkg::*;
;
logic sys_clk = 1'b0;
logic arst_n = 1'b0;
logic por_n = 1'b0;
logic always_on_fuse = 1'b0;
logic [`WDTU_ADDR_W-1:0] awaddr = '0;
logic awvalid = 1'b0;
logic awready;
logic [31:0] wdata = 32'h0;
logic [3:0] wstrb = 4'h0;
logic wvalid = 1'b0;
logic wready;
logic [1:0] bresp;
logic bvalid;
logic bready = 1'b0;
logic [`WDTU_ADDR_W-1:0] araddr = '0;
logic arvalid = 1'b0;
logic arready;
logic [31:0] rdata;
logic [1:0] rresp;
logic rvalid;
logic rready = 1'b0;
logic timeout_irq;
logic sys_reset_req;
int failures = 0;
int checks = 0;
// periods scale with the divider; 2048 ticks at code 0
localparam int TB_DIV = 4;
localparam int PERIOD = TB_DIV << `WDTU_BASE_SHIFT;

wdtu_core #(.OSC_DIV(TB_DIV)) u_wdtu_core (.sys_clk(sys_clk), .arst_n(arst_n), .por_n(por_n),
    .always_on_fuse(always_on_fuse),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .timeout_irq(timeout_irq), .sys_reset_req(sys_reset_req));

always #10 sys_clk = ~sys_clk;

////////////////////////////////////////////////////////////////////////////////
task automatic finish_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
        $display("*** PASS ***");
    end else begin
        $display("*** FAIL ***");
    end
    $finish;
endtask

task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
        failures++;
        $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
endtask

// wstrb 0 is allowed on purpose, to show the write is ignored
task automatic axi_wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s, input logic [1:0] er);
    bit done;
    done = 1'b0;
    @(posedge sys_clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h0, d};
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int i = 0; i < 100 && !done; i++) begin
        @(posedge sys_clk);
        if (awvalid && awready) awvalid <= 1'b0;
        if (wvalid && wready) wvalid <= 1'b0;
        if (bvalid === 1'b1) begin
            chk({30'h0, bresp}, {30'h0, er});
            bready <= 1'b0;
            done = 1'b1;
        end
    end
    if (!done) chk(32'h0, 32'h1);
endtask

task automatic wr(input logic [11:0] a, input logic [7:0] d);
    axi_wr(a, d, 4'hf, `WDTU_RESP_OKAY);
endtask

task automatic rdc(input logic [11:0] a, input logic [7:0] exp, input logic [1:0] er);
    bit done;
    done = 1'b0;
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int i = 0; i < 100 && !done; i++) begin
        @(posedge sys_clk);
        if (arvalid && arready) arvalid <= 1'b0;
        if (rvalid === 1'b1) begin
            chk(rdata, {24'h0, exp});
            chk({30'h0, rresp}, {30'h0, er});
            rready <= 1'b0;
            done = 1'b1;
        end
    end
    if (!done) chk(32'h0, 32'h1);
endtask

// waits for the irq (sel 0) or the reset request (sel 1); a reset while waiting for the irq is a fault
task automatic wait_to(input bit sel, input int lo, input int hi);
    int n;
    bit other;
    n = 0;
    other = 1'b0;
    while (n <= hi && ((sel ? sys_reset_req : timeout_irq) !== 1'b1)) begin
        @(posedge sys_clk);
        n++;
        other |= (sel ? 1'b0 : sys_reset_req);
    end
    chk({31'h0, other}, 32'h0);
    chk({31'h0, (n >= lo && n <= hi)}, 32'h1);
endtask

task automatic do_reset(input logic fuse, input logic por);
    @(posedge sys_clk);
    arst_n <= 1'b0;
    por_n <= ~por;
    always_on_fuse <= fuse;
    repeat (10) @(posedge sys_clk);
    arst_n <= 1'b1;
    por_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
endtask

////////////////////////////////////////////////////////////////////////////////
task automatic t_level1_reset();
    rdc(`WDTU_OFS_CSR, 8'h00, `WDTU_RESP_OKAY);
    rdc(`WDTU_OFS_RST, 8'h00, `WDTU_RESP_OKAY);
    rdc(`WDTU_OFS_CMD, 8'h00, `WDTU_RESP_OKAY);
    rdc(12'h010, 8'h00, `WDTU_RESP_SLVERR);
    axi_wr(12'h002, 8'h08, 4'hf, `WDTU_RESP_SLVERR);
    axi_wr(`WDTU_OFS_CSR, 8'h08, 4'h0, `WDTU_RESP_OKAY);
    rdc(`WDTU_OFS_CSR, 8'h00, `WDTU_RESP_OKAY);
    wr(`WDTU_OFS_CSR, 8'h10);
    rdc(`WDTU_OFS_CSR, 8'h00, `WDTU_RESP_OKAY);
    $display("test level1_reset done");
endtask

task automatic t_level1_protect();
    wr(`WDTU_OFS_CSR, 8'h08);
    rdc(`WDTU_OFS_CSR, 8'h08, `WDTU_RESP_OKAY);
    wr(`WDTU_OFS_CSR, 8'h2b);
    rdc(`WDTU_OFS_CSR, 8'h2b, `WDTU_RESP_OKAY);
    wr(`WDTU_OFS_CSR, 8'h23);
    rdc(`WDTU_OFS_CSR, 8'h2b, `WDTU_RESP_OKAY);
    wr(`WDTU_OFS_CCP, 8'h55);
    wr(`WDTU_OFS_CSR, 8'h23);
    rdc(`WDTU_OFS_CSR, 8'h2b, `WDTU_RESP_OKAY);
    wr(`WDTU_OFS_CCP, `WDTU_SIGNATURE);
    repeat (10) @(posedge sys_clk);
    wr(`WDTU_OFS_CSR, 8'h23);
    rdc(`WDTU_OFS_CSR, 8'h2b, `WDTU_RESP_OKAY);
    wr(`WDTU_OFS_CCP, `WDTU_SIGNATURE);
    wr(`WDTU_OFS_CSR, 8'h23);
    rdc(`WDTU_OFS_CSR, 8'h23, `WDTU_RESP_OKAY);
    $display("test level1_protect done");
endtask

task automatic t_vector();
    wr(`WDTU_OFS_CSR, 8'h48);
    rdc(`WDTU_OFS_CSR, 8'h48, `WDTU_RESP_OKAY);
    chk({31'h0, timeout_irq}, 32'h0);
    wr(`WDTU_OFS_CSR, 8'hc8);
    rdc(`WDTU_OFS_CSR, 8'h48, `WDTU_RESP_OKAY);
    wr(`WDTU_OFS_CMD, 8'h01);
    rdc(`WDTU_OFS_CMD, 8'h00, `WDTU_RESP_OKAY);
    wr(`WDTU_OFS_CMD, 8'h02);
    rdc(`WDTU_OFS_CSR, 8'h08, `WDTU_RESP_OKAY);
    chk({31'h0, sys_reset_req}, 32'h0);
    wr(`WDTU_OFS_CSR, 8'h48);
    rdc(`WDTU_OFS_CSR, 8'h48, `WDTU_RESP_OKAY);
    $display("test vector done");
endtask

task automatic t_timeout();
    do_reset(1'b0, 1'b1);
    wr(`WDTU_OFS_CSR, 8'h40);
    wait_to(1'b0, PERIOD - TB_DIV, PERIOD);
    chk({31'h0, timeout_irq}, 32'h1);
    rdc(`WDTU_OFS_CSR, 8'hc0, `WDTU_RESP_OKAY);
    wr(`WDTU_OFS_CSR, 8'hc0);
    rdc(`WDTU_OFS_CSR, 8'h40, `WDTU_RESP_OKAY);
    chk({31'h0, timeout_irq}, 32'h0);
    wr(`WDTU_OFS_CSR, 8'h48);
    wr(`WDTU_OFS_CMD, 8'h01);
    wait_to(1'b0, PERIOD - TB_DIV, PERIOD);
    rdc(`WDTU_OFS_CSR, 8'hc8, `WDTU_RESP_OKAY);
    wait_to(1'b1, PERIOD - 64, PERIOD);
    rdc(`WDTU_OFS_RST, 8'h08, `WDTU_RESP_OKAY);
    do_reset(1'b0, 1'b0);
    rdc(`WDTU_OFS_CSR, 8'h08, `WDTU_RESP_OKAY);
    wr(`WDTU_OFS_CSR, 8'h00);
    rdc(`WDTU_OFS_CSR, 8'h08, `WDTU_RESP_OKAY);
    wr(`WDTU_OFS_RST, 8'h00);
    rdc(`WDTU_OFS_RST, 8'h00, `WDTU_RESP_OKAY);
    rdc(`WDTU_OFS_CSR, 8'h00, `WDTU_RESP_OKAY);
    $display("test timeout done");
endtask

task automatic t_level2();
    do_reset(1'b1, 1'b0);
    rdc(`WDTU_OFS_CSR, 8'h08, `WDTU_RESP_OKAY);
    wr(`WDTU_OFS_CSR, 8'h00);
    rdc(`WDTU_OFS_CSR, 8'h08, `WDTU_RESP_OKAY);
    wr(`WDTU_OFS_CSR, 8'h01);
    rdc(`WDTU_OFS_CSR, 8'h08, `WDTU_RESP_OKAY);
    wr(`WDTU_OFS_CCP, `WDTU_SIGNATURE);
    wr(`WDTU_OFS_CSR, 8'h03);
    rdc(`WDTU_OFS_CSR, 8'h0b, `WDTU_RESP_OKAY);
    wr(`WDTU_OFS_CCP, `WDTU_SIGNATURE);
    wr(`WDTU_OFS_CSR, 8'h01);
    wr(`WDTU_OFS_CSR, 8'h05);
    rdc(`WDTU_OFS_CSR, 8'h09, `WDTU_RESP_OKAY);
    wait_to(1'b1, 2 * PERIOD - 256, 2 * PERIOD);
    $display("test level2 done");
endtask

////////////////////////////////////////////////////////////////////////////////
// four time-outs make about 42000 cycles; 60000 leaves a margin
initial begin
    repeat (60000) @(posedge sys_clk);
    failures++;
    finish_test();
end

initial begin
    do_reset(1'b0, 1'b1);
    t_level1_reset();
    t_level1_protect();
    t_vector();
    t_timeout();
    t_level2();
    finish_test();
end
endmodule

// ==== rtl/wdtu_core.sv ====
/*
 watchdog timer unit: counter, mode logic, protected writes, axi4-lite slave.
 assumes one 50 MHz clock, the cpu pulses restart and vector through a command register,
 and the reset request is caught by the reset controller which then applies arst_n.
*/
//
// Overview of operation
// - counter advances on a 128 kHz oscillator tick, independent of bus traffic.
// - restart command clears the counter so the period starts from zero.
// - counter clears while disabled and on any device reset.
// - ten time-out lengths in oscillator cycles, chosen by prescale field.
// - in reset mode an elapsed period requests a system reset.
// - fuse unprogrammed: starts disabled, disable needs unlock, period free.
// - fuse programmed: always enabled, reset-enable reads one, period change needs unlock.
// - level 1 plain write of one to reset-enable enables watchdog.
// - level 2 period change after unlock; written reset-enable value ignored.
// - bit 7 flag set on time-out in interrupt operation.
// - flag cleared by vector execution or writing one.
// - interrupt request while flag and bit 6 enable are both set.
// - mode from reset-enable and irq-enable; programmed fuse forces reset only.
// - combined mode: first time-out sets flag; vector clears enable and flag.
// - combined mode: unserviced flag at next time-out gives system reset.
// - reset-enable reads set while reset flag set; clearable only after.
// - bit 4 reserved, reads zero.
// - prescale bits 5 and 2:0; 2048 to 1048576 cycles; codes above 9 reserved.
// - reset flag set by watchdog reset; cleared by power-on or writing zero.
//
`timescale 1ns/10ps
`include "wdtu_params.svh"
module wdtu_core
    import wdtu_pkg::*;
#(
    parameter int OSC_DIV = `WDTU_OSC_DIV // sys_clk cycles per oscillator tick
)
(
    input wire logic sys_clk, // 50 MHz clock
    input wire logic arst_n, // async reset, active low
    input wire logic por_n, // power-on reset, active low
    input wire logic always_on_fuse, // 1 = programmed (level 2)
    input wire logic [`WDTU_ADDR_W-1:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [`WDTU_ADDR_W-1:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    output logic timeout_irq, // watchdog interrupt request
    output logic sys_reset_req // one-cycle system reset request
);
    //////////////////////////////////////////////////////////////////////////////
    // state
    logic timeout_irq_flag_ff;
    logic timeout_irq_enable_ff;
    logic system_reset_enable_ff;
    logic [3:0] timeout_prescale_select_ff;
    logic watchdog_reset_flag_ff;
    logic [2:0] win_ff;
    wdtu_cnt_t cnt_ff;
    logic fuse_ff;
    logic fuse_cap_ff;
    wdtu_ax_e wst_ff;
    wdtu_ax_e rst_ff;
    logic aw_got_ff;
    logic w_got_ff;
    logic [`WDTU_ADDR_W-1:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;

    wdtu_tick_if tk ();

    wdtu_osc_div #(
        .OSC_DIV(OSC_DIV)
    ) u_div (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .tk(tk)
    );

    //////////////////////////////////////////////////////////////////////////////
    // fuse strap caught after reset release; forced level 2 lasts until reset
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            fuse_cap_ff <= 1'b0;
            fuse_ff <= 1'b0;
        end else if (!fuse_cap_ff) begin
            fuse_cap_ff <= 1'b1;
            fuse_ff <= always_on_fuse;
        end
    end

    //////////////////////////////////////////////////////////////////////////////
    // axi4-lite write channel
    logic wr_fire;
    logic wr_ok;
    logic wr_csr;
    logic wr_ccp;
    logic wr_rst;
    logic wr_cmd;
    logic [7:0] wb;
    assign wr_fire = (wst_ff == WDTU_AX_IDLE) && aw_got_ff && w_got_ff;
    assign wr_ok = wstrb_ff[0];
    assign wb = wdata_ff[7:0];
    assign wr_csr = wr_fire && wr_ok && (awaddr_ff == `WDTU_OFS_CSR);
    assign wr_ccp = wr_fire && wr_ok && (awaddr_ff == `WDTU_OFS_CCP);
    assign wr_rst = wr_fire && wr_ok && (awaddr_ff == `WDTU_OFS_RST);
    assign wr_cmd = wr_fire && wr_ok && (awaddr_ff == `WDTU_OFS_CMD);

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            awaddr_ff <= '0;
            wdata_ff <= '0;
            wstrb_ff <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `WDTU_RESP_OKAY;
            wst_ff <= WDTU_AX_IDLE;
        end else begin
            s_axi_awready <= (wst_ff == WDTU_AX_IDLE) && !aw_got_ff && !s_axi_awready;
            s_axi_wready <= (wst_ff == WDTU_AX_IDLE) && !w_got_ff && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            case (wst_ff)
                WDTU_AX_IDLE: begin
                    if (wr_fire) begin
                        aw_got_ff <= 1'b0;
                        w_got_ff <= 1'b0;
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp <= (awaddr_ff[`WDTU_ADDR_W-1:4] == '0 && awaddr_ff[1:0] == 2'b00)
                            ? `WDTU_RESP_OKAY : `WDTU_RESP_SLVERR;
                        wst_ff <= WDTU_AX_RESP;
                    end
                end
                WDTU_AX_RESP: begin
                    if (s_axi_bready) begin
                        s_axi_bvalid <= 1'b0;
                        wst_ff <= WDTU_AX_IDLE;
                    end
                end
                default: wst_ff <= WDTU_AX_IDLE;
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////////
    // protected-change window
    logic prot_wr;
    logic win_open;
    assign win_open = (win_ff != 3'h0);
    assign prot_wr = wr_csr && win_open;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            win_ff <= 3'h0;
        end else if (wr_ccp && wb == `WDTU_SIGNATURE) begin
            win_ff <= `WDTU_WIN_CYC;
        end else if (prot_wr) begin
            win_ff <= 3'h0;
        end else if (win_open) begin
            win_ff <= win_ff - 3'h1;
        end
    end

    //////////////////////////////////////////////////////////////////////////////
    // mode and timing
    logic re_eff;
    logic enabled;
    logic timeout;
    logic vector_exec;
    logic restart;
    logic [`WDTU_CNT_W-1:0] limit;
    wdtu_mode_e mode;
    assign re_eff = system_reset_enable_ff | watchdog_reset_flag_ff | fuse_ff;
    always_comb begin
        if (fuse_ff) begin
            mode = WDTU_MODE_RST;
        end else begin
            mode = wdtu_mode_e'({re_eff, timeout_irq_enable_ff});
        end
    end
    assign enabled = (mode != WDTU_MODE_STOP);
    assign vector_exec = wr_cmd && wb[`WDTU_B_CMD_VECTOR];
    assign restart = wr_cmd && wb[`WDTU_B_CMD_RESTART];
    // reserved codes fall back to the longest period
    assign limit = (timeout_prescale_select_ff > `WDTU_PRE_MAX)
        ? (`WDTU_CNT_W'(1) << (`WDTU_BASE_SHIFT + 9))
        : (`WDTU_CNT_W'(1) << (`WDTU_BASE_SHIFT + timeout_prescale_select_ff));
    // a count left above a freshly shortened period still expires at the next tick
    assign timeout = enabled && tk.tick && (cnt_ff >= limit - `WDTU_CNT_W'(1));

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_ff <= '0;
        end else if (restart || !enabled || timeout) begin
            cnt_ff <= '0;
        end else if (tk.tick) begin
            cnt_ff <= cnt_ff + `WDTU_CNT_W'(1);
        end
    end

    logic rst_now;
    always_comb begin
        case (mode)
            WDTU_MODE_RST: rst_now = timeout;
            WDTU_MODE_BOTH: rst_now = timeout && timeout_irq_flag_ff;
            default: rst_now = 1'b0;
        endcase
    end

    //////////////////////////////////////////////////////////////////////////////
    // control/status fields
    logic irq_set;
    assign irq_set = timeout && (mode == WDTU_MODE_IRQ || mode == WDTU_MODE_BOTH);

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            timeout_irq_flag_ff <= 1'b0;
        end else if (irq_set) begin
            timeout_irq_flag_ff <= 1'b1;
        end else if (vector_exec || (wr_csr && wb[`WDTU_B_IF])) begin
            timeout_irq_flag_ff <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            timeout_irq_enable_ff <= 1'b0;
        end else if (vector_exec && mode == WDTU_MODE_BOTH) begin
            timeout_irq_enable_ff <= 1'b0;
        end else if (wr_csr) begin
            timeout_irq_enable_ff <= wb[`WDTU_B_IE];
        end
    end

    logic pre_free;
    assign pre_free = !fuse_ff || prot_wr;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            system_reset_enable_ff <= 1'b0;
            timeout_prescale_select_ff <= 4'h0;
        end else if (wr_csr) begin
            // clearing needs the window at level 1; at level 2 the written value is moot
            if (wb[`WDTU_B_RE]) begin
                system_reset_enable_ff <= 1'b1;
            end else if (prot_wr && !watchdog_reset_flag_ff) begin
                system_reset_enable_ff <= 1'b0;
            end
            if (pre_free) begin
                timeout_prescale_select_ff <= {wb[`WDTU_B_P3], wb[2:0]};
            end
        end
    end

    // cleared by power-on or a written zero, not by arst_n, so it survives the watchdog reset it reports
    always_ff @(posedge sys_clk or negedge por_n) begin
        if (!por_n) begin
            watchdog_reset_flag_ff <= 1'b0;
        end else if (rst_now) begin
            watchdog_reset_flag_ff <= 1'b1;
        end else if (wr_rst && !wb[`WDTU_B_RF]) begin
            watchdog_reset_flag_ff <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sys_reset_req <= 1'b0;
            timeout_irq <= 1'b0;
        end else begin
            sys_reset_req <= rst_now;
            timeout_irq <= (timeout_irq_flag_ff || irq_set) && timeout_irq_enable_ff;
        end
    end

    //////////////////////////////////////////////////////////////////////////////
    // axi4-lite read channel
    logic [7:0] csr_rd;
    assign csr_rd = {timeout_irq_flag_ff, timeout_irq_enable_ff, timeout_prescale_select_ff[3],
        1'b0, re_eff, timeout_prescale_select_ff[2:0]};

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= `WDTU_RESP_OKAY;
            rst_ff <= WDTU_AX_IDLE;
        end else begin
            case (rst_ff)
                WDTU_AX_IDLE: begin
                    s_axi_arready <= !s_axi_arready;
                    if (s_axi_arvalid && s_axi_arready) begin
                        s_axi_arready <= 1'b0;
                        s_axi_rvalid <= 1'b1;
                        s_axi_rresp <= `WDTU_RESP_OKAY;
                        rst_ff <= WDTU_AX_RESP;
                        case (s_axi_araddr)
                            `WDTU_OFS_CSR: s_axi_rdata <= {24'h0, csr_rd};
                            `WDTU_OFS_RST: s_axi_rdata <= {28'h0, watchdog_reset_flag_ff, 3'h0};
                            `WDTU_OFS_CCP: s_axi_rdata <= 32'h0;
                            `WDTU_OFS_CMD: s_axi_rdata <= 32'h0;
                            default: begin
                                s_axi_rdata <= 32'h0;
                                s_axi_rresp <= `WDTU_RESP_SLVERR;
                            end
                        endcase
                    end
                end
                WDTU_AX_RESP: begin
                    if (s_axi_rready) begin
                        s_axi_rvalid <= 1'b0;
                        rst_ff <= WDTU_AX_IDLE;
                    end
                end
                default: rst_ff <= WDTU_AX_IDLE;
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////////
    // checks
    restart_clears_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        restart |=> cnt_ff == '0)
        else $error("restart did not clear counter");
    disabled_idle_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !enabled |=> cnt_ff == '0)
        else $error("counter ran while disabled");
    reset_pulse_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (timeout && mode == WDTU_MODE_RST) |=> sys_reset_req ##1 !sys_reset_req)
        else $error("reset mode timeout gave no one-cycle reset");
    level2_reads_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        fuse_ff |-> csr_rd[`WDTU_B_RE] && mode == WDTU_MODE_RST)
        else $error("level 2 not forced to reset mode");
    flag_sets_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        irq_set |=> timeout_irq_flag_ff)
        else $error("timeout flag not set");
    flag_clear_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (vector_exec && !irq_set) |=> !timeout_irq_flag_ff)
        else $error("vector did not clear flag");
    irq_follows_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (timeout_irq_flag_ff && timeout_irq_enable_ff) |=> timeout_irq)
        else $error("irq request missing");
    combined_second_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (timeout && mode == WDTU_MODE_BOTH && timeout_irq_flag_ff) |=> sys_reset_req)
        else $error("unserviced combined timeout gave no reset");
    flag_holds_re_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        watchdog_reset_flag_ff |-> csr_rd[`WDTU_B_RE])
        else $error("reset enable not held by reset flag");
    reserved_zero_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        csr_rd[`WDTU_B_RSV] == 1'b0)
        else $error("reserved bit not zero");
    window_len_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (wr_ccp && wb == `WDTU_SIGNATURE) |=> win_open [*4] ##1 (!win_open || $past(wr_ccp)))
        else $error("window length wrong");
endmodule

// ==== rtl/wdtu_osc_div.sv ====
/*
 divider giving one-cycle 128 kHz enable pulses from sys_clk.
 assumes sys_clk at 50 MHz.
*/
`timescale 1ns/10ps
`include "wdtu_params.svh"
module wdtu_osc_div
    import wdtu_pkg::*;
#(
    parameter int OSC_DIV = `WDTU_OSC_DIV // sys_clk cycles per tick
)
(
    input wire logic sys_clk, // system clock
    input wire logic arst_n, // async reset, active low
    wdtu_tick_if.src tk // tick out
);
    logic [`WDTU_DIV_W-1:0] cnt_ff;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_ff <= '0;
            tk.tick <= 1'b0;
        end else if (cnt_ff == `WDTU_DIV_W'(OSC_DIV - 1)) begin
            cnt_ff <= '0;
            tk.tick <= 1'b1;
        end else begin
            cnt_ff <= cnt_ff + 1'b1;
            tk.tick <= 1'b0;
        end
    end

    tick_spacing_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        tk.tick |-> (cnt_ff == '0) ##1 !tk.tick)
        else $error("oscillator tick too frequent");
endmodule

// ==== rtl/wdtu_params.svh ====
/*
 watchdog timer unit constants: register offsets, field positions, timing.
 assumes inclusion by bare name from rtl/.
*/
`ifndef WDTU_PARAMS_SVH
`define WDTU_PARAMS_SVH

// byte addresses on the register bus
`define WDTU_OFS_CSR 12'h000
`define WDTU_OFS_CCP 12'h004
`define WDTU_OFS_RST 12'h008
`define WDTU_OFS_CMD 12'h00c
`define WDTU_ADDR_W 12

// control/status bit positions
`define WDTU_B_IF 7
`define WDTU_B_IE 6
`define WDTU_B_P3 5
`define WDTU_B_RSV 4
`define WDTU_B_RE 3
// reset cause bit position
`define WDTU_B_RF 3
// command bits
`define WDTU_B_CMD_RESTART 0
`define WDTU_B_CMD_VECTOR 1

`define WDTU_SIGNATURE 8'hd8
`define WDTU_PRE_MAX 4'h9
`define WDTU_WIN_CYC 3'h4
`define WDTU_CNT_W 21
// 2048 oscillator cycles for code 0, doubling per code
`define WDTU_BASE_SHIFT 11

// oscillator tick: 50 MHz / 128 kHz = 390.625, rounded down
`define WDTU_SYS_KHZ 50000
`define WDTU_OSC_KHZ 128
`define WDTU_OSC_DIV (`WDTU_SYS_KHZ / `WDTU_OSC_KHZ)
`define WDTU_DIV_W 9

// axi response codes
`define WDTU_RESP_OKAY 2'h0
`define WDTU_RESP_SLVERR 2'h2

`endif

// ==== rtl/wdtu_pkg.sv ====
/*
 watchdog timer unit types.
 assumes wdtu_params.svh sits beside it.
*/
`include "wdtu_params.svh"
package wdtu_pkg;
    typedef enum logic [1:0] {
        WDTU_MODE_STOP = 2'b00,
        WDTU_MODE_IRQ = 2'b01,
        WDTU_MODE_RST = 2'b10,
        WDTU_MODE_BOTH = 2'b11
    } wdtu_mode_e;
    typedef enum logic [1:0] {
        WDTU_AX_IDLE = 2'b00,
        WDTU_AX_RESP = 2'b01
    } wdtu_ax_e;
    typedef logic [`WDTU_CNT_W-1:0] wdtu_cnt_t;
endpackage

// ==== rtl/wdtu_tick_if.sv ====
/*
 carrier between core and oscillator tick divider.
 assumes one clock domain.
*/
`timescale 1ns/10ps
interface wdtu_tick_if;
    logic tick;
    modport src (output tick);
    modport dst (input tick);
endinterface
